// ### src/owm_monitor.sv
// How it works
// [RULE_01] upper window bit: set 105%, clear 110%
// [RULE_02] lower window bit: set 95%, clear 90%
// [RULE_03] thresholds are fractions of present setpoint
// [RULE_04] threshold config register writable over bus
// [RULE_05] host keeps regulation field on limit writes
// [RULE_06] warnings only indicate, never shut down
// [RULE_07] temperature above 120 raises warning
// [RULE_08] warning clears only below 117
// [RULE_09] pin pulled low outside the window
// [RULE_10] window checked only at steady state
// [RULE_11] pin held low for 0-150ms delay
// [RULE_12] monitoring stays active across margin moves
// [RULE_13] warning drives pin low, status bit 0; code does not drive the pin for an external-low warning
// [RULE_14] back inside window releases pin, bit 1
// [RULE_15] external low on pin is a warning
// [RULE_16] turn-off: low at command or ramp start
// [RULE_17] manager polls status of every converter
`timescale 1ns/1ps
`default_nettype none
`include "owm_regs.svh"
module owm_monitor #(
  parameter int CYCLES_PER_MS = `OWM_CLK_HZ / `OWM_MS_PER_S,
  parameter logic [7:0] UV_PCT0 = 8'h55,
  parameter logic [7:0] UV_PCT1 = 8'h50,
  parameter logic [7:0] UV_PCT2 = 8'h4B
) (
  input wire logic clk, // system clock, 40 MHz
  input wire logic reset, // synchronous, active high
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, valid after reg_rd
  input wire logic [11:0] vout_setpoint, // present setpoint incl. margin
  input wire logic [11:0] vout_measured, // measured output voltage
  input wire logic [7:0] temp_c, // controller temperature, deg C
  input wire logic steady_state, // output at steady level
  input wire logic turn_off_cmd, // turn-off command pulse
  input wire logic ramping_down, // output voltage is falling
  input wire logic pg_i, // power-good pin level
  output logic pg_o, // power-good pin drive value
  output logic pg_oe, // high while pulling the pin low
  output logic pg_warning, // power-good warning active
  output logic overtemp_warning, // overtemperature warning active
  output logic [19:0] ov_threshold, // setpoint times overvoltage pct
  output logic [19:0] uv_threshold, // setpoint times undervoltage pct
  output logic [3:0] current_limit_level, // limit setpoint field
  output logic limit_temp_comp_enable, // limit tempco enable
  output logic [2:0] load_regulation_slope // regulation slope field
);
  import owm_pkg::*;

  // ----------------------------------------
  // threshold scaling
  // ----------------------------------------
  localparam int NSCALE = 5;
  localparam int IDX_HI = 0;
  localparam int IDX_LO = 1;
  localparam int IDX_OV = 2;
  localparam int IDX_UV = 3;
  localparam int IDX_MEAS = 4;

  owm_core_t s;
  owm_core_t next_s;
  logic [7:0] pct [NSCALE];
  logic [11:0] scale_in [NSCALE];
  logic [19:0] scaled [NSCALE];
  logic pin_level;
  logic window_bad;
  logic ext_low;
  logic [7:0] st_word;

  always_comb begin
    pct[IDX_HI] = s.ptc[`OWM_PTC_UPPER] ? `OWM_PCT_HI_TIGHT
                                        : `OWM_PCT_HI_WIDE; // RULE_01
    pct[IDX_LO] = s.ptc[`OWM_PTC_LOWER] ? `OWM_PCT_LO_TIGHT
                                        : `OWM_PCT_LO_WIDE; // RULE_02
    case (s.ptc[3:2])
      2'b00: pct[IDX_OV] = `OWM_PCT_OV0;
      2'b01: pct[IDX_OV] = `OWM_PCT_OV1;
      default: pct[IDX_OV] = `OWM_PCT_OV2;
    endcase
    case (s.ptc[1:0])
      2'b00: pct[IDX_UV] = UV_PCT0;
      2'b01: pct[IDX_UV] = UV_PCT1;
      default: pct[IDX_UV] = UV_PCT2;
    endcase
    pct[IDX_MEAS] = `OWM_PCT_UNITY;
    for (int i = 0; i < NSCALE; i++) begin
      scale_in[i] = (i == IDX_MEAS) ? vout_measured : vout_setpoint; // RULE_03
    end
  end

  genvar g;
  generate
    for (g = 0; g < NSCALE; g++) begin : gen_scale
      owm_scale #(.W(12)) u_scale (
        .value(scale_in[g]),
        .pct(pct[g]),
        .product(scaled[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // pin input
  // ----------------------------------------
  owm_sync u_pin_sync (
    .clk(clk),
    .reset(reset),
    .async_in(pg_i),
    .sync_out(pin_level)
  );

  // window follows the setpoint, so margin moves rescale it live
  assign window_bad = (scaled[IDX_MEAS] > scaled[IDX_HI]) ||
                      (scaled[IDX_MEAS] < scaled[IDX_LO]); // RULE_12
  // ignore own release until the synchroniser has caught up
  assign ext_low = !pin_level && !s.pg_drive && (s.quiet == 2'b11); // RULE_15

  always_comb begin
    st_word = 8'h00;
    st_word[`OWM_ST_OK] = !s.pg_warn; // RULE_13
    st_word[`OWM_ST_TEMP] = s.temp_warn;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.ov_thr = scaled[IDX_OV];
    next_s.uv_thr = scaled[IDX_UV];
    // registers
    if (reg_wr) begin
      if (reg_addr == `OWM_ADDR_CLS) begin
        next_s.current_limit_setpoint = reg_wdata;
      end else if (reg_addr == `OWM_ADDR_PTC) begin
        next_s.ptc = reg_wdata[5:0]; // RULE_04
      end else if (reg_addr == `OWM_ADDR_DLY) begin
        next_s.dly = (reg_wdata > `OWM_DLY_MAX_MS) ? `OWM_DLY_MAX_MS
                                                   : reg_wdata; // RULE_11
      end else if (reg_addr == `OWM_ADDR_OPT) begin
        next_s.opt_now = reg_wdata[0];
      end
    end
    if (reg_rd) begin
      if (reg_addr == `OWM_ADDR_CLS) begin
        next_s.rdata = s.current_limit_setpoint;
      end else if (reg_addr == `OWM_ADDR_PTC) begin
        next_s.rdata = {2'b00, s.ptc};
      end else if (reg_addr == `OWM_ADDR_DLY) begin
        next_s.rdata = s.dly;
      end else if (reg_addr == `OWM_ADDR_ST) begin
        next_s.rdata = st_word;
      end else if (reg_addr == `OWM_ADDR_OPT) begin
        next_s.rdata = {7'h00, s.opt_now};
      end else begin
        next_s.rdata = 8'h00;
      end
    end
    // temperature with hysteresis
    if (temp_c > `OWM_TEMP_SET) begin
      next_s.temp_warn = 1'b1; // RULE_07
    end else if (temp_c < `OWM_TEMP_CLR) begin
      next_s.temp_warn = 1'b0; // RULE_08
    end
    // power-good sequence
    case (s.state)
      OWM_OFF: begin
        next_s.ms_cnt = 16'h0000;
        next_s.dly_cnt = 8'h00;
        if (steady_state) begin
          next_s.state = OWM_WAIT; // RULE_10
        end
      end
      OWM_WAIT: begin
        if (!steady_state) begin
          next_s.state = OWM_OFF;
        end else if (turn_off_cmd) begin
          next_s.state = OWM_TURNOFF;
        end else if (s.dly_cnt >= s.dly) begin
          next_s.state = OWM_MONITOR; // RULE_11
        end else if (s.ms_cnt == 16'(CYCLES_PER_MS - 1)) begin
          next_s.ms_cnt = 16'h0000;
          next_s.dly_cnt = s.dly_cnt + 8'h01;
        end else begin
          next_s.ms_cnt = s.ms_cnt + 16'h0001;
        end
      end
      OWM_MONITOR: begin
        if (turn_off_cmd) begin
          next_s.state = OWM_TURNOFF;
        end else if (!steady_state) begin
          next_s.state = OWM_OFF;
        end
      end
      default: begin
        if (!steady_state && ramping_down) begin
          next_s.state = OWM_OFF;
        end
      end
    endcase
    // indications only; nothing here turns the output off
    next_s.pg_warn = (next_s.state == OWM_MONITOR) &&
                     (window_bad || ext_low); // RULE_06
    case (next_s.state)
      OWM_MONITOR: next_s.pg_drive = window_bad; // RULE_09 RULE_14
      OWM_TURNOFF: next_s.pg_drive = s.opt_now || ramping_down; // RULE_16
      default: next_s.pg_drive = 1'b1; // RULE_11
    endcase
    // the pin only reads high two flops after our own release
    next_s.quiet = next_s.pg_drive ? 2'b00 : {s.quiet[0], !s.pg_drive};
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      s.state <= OWM_OFF;
      s.current_limit_setpoint <= `OWM_RST_CLS;
      s.ptc <= `OWM_RST_PTC;
      s.dly <= `OWM_RST_DLY;
      s.opt_now <= `OWM_RST_OPT;
      s.temp_warn <= 1'b0;
      s.pg_warn <= 1'b0;
      s.pg_drive <= 1'b1;
      s.quiet <= 2'b00;
      s.ms_cnt <= 16'h0000;
      s.dly_cnt <= 8'h00;
      s.rdata <= 8'h00;
      s.ov_thr <= 20'h00000;
      s.uv_thr <= 20'h00000;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = s.rdata;
  assign pg_o = 1'b0;
  assign pg_oe = s.pg_drive;
  assign pg_warning = s.pg_warn;
  assign overtemp_warning = s.temp_warn;
  assign ov_threshold = s.ov_thr;
  assign uv_threshold = s.uv_thr;
  assign current_limit_level = s.current_limit_setpoint[3:0];
  assign limit_temp_comp_enable = s.current_limit_setpoint[4];
  assign load_regulation_slope = s.current_limit_setpoint[7:5];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence seq_enter_wait;
    s.state == OWM_OFF && steady_state && s.dly == 8'h00;
  endsequence

  sequence seq_wait_to_monitor;
    s.state == OWM_WAIT ##1 s.state == OWM_MONITOR;
  endsequence

  a_upper_select: assert property (@(posedge clk) disable iff (reset) // RULE_01
    pct[IDX_HI] == (s.ptc[`OWM_PTC_UPPER] ? 8'h69 : 8'h6E))
    else $error("upper window percent wrong");

  a_lower_select: assert property (@(posedge clk) disable iff (reset) // RULE_02
    pct[IDX_LO] == (s.ptc[`OWM_PTC_LOWER] ? 8'h5F : 8'h5A))
    else $error("lower window percent wrong");

  a_temp_raise: assert property (@(posedge clk) disable iff (reset) // RULE_07
    temp_c > 8'h78 |=> overtemp_warning)
    else $error("overtemp warning not raised");

  a_temp_hyst: assert property (@(posedge clk) disable iff (reset) // RULE_08
    overtemp_warning && temp_c >= 8'h75 |=> overtemp_warning)
    else $error("overtemp warning dropped early");

  a_temp_clear: assert property (@(posedge clk) disable iff (reset) // RULE_08
    temp_c < 8'h75 |=> !overtemp_warning)
    else $error("overtemp warning not cleared");

  a_window_low: assert property (@(posedge clk) disable iff (reset) // RULE_09
    s.state == OWM_MONITOR && steady_state && !turn_off_cmd && window_bad
    |=> pg_oe && pg_warning)
    else $error("pin not pulled low outside window");

  a_no_early_warn: assert property (@(posedge clk) disable iff (reset) // RULE_10
    s.state != OWM_MONITOR |-> !pg_warning)
    else $error("warning before steady state");

  a_delay_hold: assert property (@(posedge clk) disable iff (reset) // RULE_11
    s.state == OWM_WAIT |=> $past(pg_oe) && (s.state != OWM_MONITOR ||
    $past(s.dly_cnt) >= $past(s.dly)))
    else $error("pin released before delay");

  a_zero_delay: assert property (@(posedge clk) disable iff (reset) // RULE_11
    seq_enter_wait ##1 steady_state && !turn_off_cmd |-> ##0 seq_wait_to_monitor)
    else $error("zero delay not honoured");

  a_status_bit: assert property (@(posedge clk) disable iff (reset) // RULE_13
    reg_rd && reg_addr == `OWM_ADDR_ST |=> reg_rdata[0] == !$past(pg_warning))
    else $error("status bit does not mirror warning");

  a_window_release: assert property (@(posedge clk) disable iff (reset) // RULE_14
    s.state == OWM_MONITOR && steady_state && !turn_off_cmd && !window_bad
    |=> !pg_oe)
    else $error("pin not released inside window");

  a_external_low: assert property (@(posedge clk) disable iff (reset) // RULE_15
    s.state == OWM_MONITOR && steady_state && !turn_off_cmd && ext_low
    |=> pg_warning)
    else $error("external low not reported");

  a_off_now: assert property (@(posedge clk) disable iff (reset) // RULE_16
    s.state == OWM_MONITOR && turn_off_cmd && s.opt_now |=> pg_oe)
    else $error("pin not pulled low at turn-off");
endmodule // owm_monitor
`default_nettype wire

// ### src/owm_pkg.sv
package owm_pkg;
  typedef enum logic [1:0] {
    OWM_OFF = 2'b00,
    OWM_WAIT = 2'b01,
    OWM_MONITOR = 2'b10,
    OWM_TURNOFF = 2'b11
  } owm_state_t;

  typedef struct packed {
    logic meta;
    logic level;
  } owm_sync_t;

  typedef struct packed {
    owm_state_t state;
    logic [7:0] current_limit_setpoint;
    logic [5:0] ptc;
    logic [7:0] dly;
    logic opt_now;
    logic temp_warn;
    logic pg_warn;
    logic pg_drive;
    logic [1:0] quiet;
    logic [15:0] ms_cnt;
    logic [7:0] dly_cnt;
    logic [7:0] rdata;
    logic [19:0] ov_thr;
    logic [19:0] uv_thr;
  } owm_core_t;
endpackage

// ### src/owm_regs.svh
`ifndef OWM_REGS_SVH
`define OWM_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OWM_ADDR_CLS 8'h08
`define OWM_ADDR_PTC 8'h0C
`define OWM_ADDR_DLY 8'h0D
`define OWM_ADDR_ST 8'h0E
`define OWM_ADDR_OPT 8'h0F
// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define OWM_RST_CLS 8'h1B
`define OWM_RST_PTC 6'h08
`define OWM_RST_DLY 8'h00
`define OWM_RST_OPT 1'h0
`define OWM_PTC_UPPER 5
`define OWM_PTC_LOWER 4
`define OWM_ST_OK 0
`define OWM_ST_TEMP 1
// ----------------------------------------
// levels and timing
// ----------------------------------------
`define OWM_PCT_UNITY 8'h64
`define OWM_PCT_HI_TIGHT 8'h69
`define OWM_PCT_HI_WIDE 8'h6E
`define OWM_PCT_LO_TIGHT 8'h5F
`define OWM_PCT_LO_WIDE 8'h5A
`define OWM_PCT_OV0 8'h6E
`define OWM_PCT_OV1 8'h78
`define OWM_PCT_OV2 8'h82
`define OWM_TEMP_SET 8'h78
`define OWM_TEMP_CLR 8'h75
`define OWM_DLY_MAX_MS 8'h96
`define OWM_CLK_HZ 40000000
`define OWM_MS_PER_S 1000
`endif

// ### src/owm_scale.sv
`timescale 1ns/1ps
`default_nettype none
module owm_scale #(
  parameter int W = 12
) (
  input wire logic [W-1:0] value, // voltage code
  input wire logic [7:0] pct, // percentage factor
  output logic [W+7:0] product // value times percent
);
  // exact hundredths, compared against measured times one hundred
  assign product = value * pct;
endmodule // owm_scale
`default_nettype wire

// ### src/owm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module owm_sync (
  input wire logic clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic async_in, // level from outside the domain
  output logic sync_out // level after two flops
);
  import owm_pkg::*;
  owm_sync_t s;
  owm_sync_t next_s;

  always_comb begin
    next_s.meta = async_in;
    next_s.level = s.meta;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= 2'h3;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.level;
endmodule // owm_sync
`default_nettype wire

// ### tb/owm_mgr_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "owm_regs.svh"
module owm_mgr_model (
  input wire logic clk, // clock
  input wire logic reset, // sync reset
  input wire logic poll_en, // keep polling
  input wire logic go, // request, held to done
  input wire logic [1:0] op, // 0 rd, 1 wr, 2 rmw
  input wire logic [7:0] addr, // offset
  input wire logic [7:0] wdata, // new bits
  input wire logic [7:0] mask, // rmw bits
  output logic done, // request over
  output logic [7:0] rdata, // read value
  output logic [7:0] status, // polled status
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [7:0] reg_addr, // offset
  output logic [7:0] reg_wdata, // data
  input wire logic [7:0] reg_rdata // read data
);
  typedef enum logic [1:0] {M_IDLE, M_WAIT, M_TAKE, M_DONE} owm_mst_t;
  owm_mst_t st;
  logic poll;
  // ---
  // bus sequencer
  // ---
  always_ff @(posedge clk) begin
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~reg_addr; // released bus keeps moving
    reg_wdata <= ~reg_wdata;
    if (reset) begin
      st <= M_IDLE;
      done <= 1'b0;
      poll <= 1'b0;
      rdata <= 8'h00;
      status <= 8'h00;
    end else begin
      case (st)
        M_IDLE: begin
          if (go) begin
            reg_addr <= addr;
            reg_wdata <= wdata;
            reg_wr <= (op == 2'h1);
            reg_rd <= (op != 2'h1);
            poll <= 1'b0;
            st <= (op == 2'h1) ? M_DONE : M_WAIT;
          end else if (poll_en) begin
            reg_addr <= `OWM_ADDR_ST;
            reg_rd <= 1'b1;
            poll <= 1'b1;
            st <= M_WAIT;
          end
        end
        M_WAIT: st <= M_TAKE;
        M_TAKE: begin
          st <= poll ? M_IDLE : M_DONE;
          if (poll) status <= reg_rdata;
          else rdata <= reg_rdata;
          if (!poll && op == 2'h2) begin
            reg_addr <= addr;
            reg_wdata <= (reg_rdata & ~mask) | (wdata & mask);
            reg_wr <= 1'b1;
          end
        end
        default: begin
          done <= go;
          if (!go) st <= M_IDLE;
        end
      endcase
    end
  end
endmodule // owm_mgr_model
`default_nettype wire

// ### tb/test_output_warning_threshold_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "owm_regs.svh"
`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); \
  end \
end
module test_output_warning_threshold_monitor;
  localparam int CPM = 4;
  localparam logic [7:0] RA [5] = '{`OWM_ADDR_CLS, `OWM_ADDR_PTC,
    `OWM_ADDR_DLY, `OWM_ADDR_OPT, 8'h42};
  localparam logic [7:0] RV [5] = '{8'h1B, 8'h08, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] TT [7] = '{8'h79, 8'h76, 8'h75, 8'h74, 8'h78,
    8'hC8, 8'h00};
  localparam logic TW [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  logic clk, reset, poll_en, go, done, steady_state, turn_off_cmd;
  logic ramping_down, ext_low, reg_wr, reg_rd, pg_o, pg_oe;
  logic pg_warning, overtemp_warning, limit_temp_comp_enable;
  logic [1:0] op;
  logic [7:0] addr, wdata, mask, rdata, status, reg_addr, reg_wdata;
  logic [7:0] reg_rdata, temp_c;
  logic [11:0] vout_setpoint, vout_measured;
  logic [19:0] ov_threshold, uv_threshold;
  logic [3:0] current_limit_level;
  logic [2:0] load_regulation_slope;
  wire logic pg_i;
  int err_count, n_tests;
  assign pg_i = pg_oe ? pg_o : ~ext_low; // pulled up when free

  owm_monitor #(.CYCLES_PER_MS(CPM), .UV_PCT0(8'h55), .UV_PCT1(8'h50),
    .UV_PCT2(8'h4B)) i_dut (.clk, .reset, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .vout_setpoint, .vout_measured, .temp_c,
    .steady_state, .turn_off_cmd, .ramping_down, .pg_i, .pg_o, .pg_oe,
    .pg_warning, .overtemp_warning, .ov_threshold, .uv_threshold,
    .current_limit_level, .limit_temp_comp_enable, .load_regulation_slope);
  owm_mgr_model i_mgr (.clk, .reset, .poll_en, .go, .op, .addr, .wdata,
    .mask, .done, .rdata, .status, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata);

  // ---
  // expectations
  // ---
  function automatic logic [7:0] ovp(input logic [1:0] c);
    if (c == 2'h0) return `OWM_PCT_OV0;
    return (c == 2'h1) ? `OWM_PCT_OV1 : `OWM_PCT_OV2;
  endfunction
  function automatic logic [7:0] uvp(input logic [1:0] c);
    return (c == 2'h0) ? 8'h55 : (c == 2'h1) ? 8'h50 : 8'h4B;
  endfunction
  function automatic logic bad(input logic [1:0] u, input int sp, m);
    int hi, lo;
    hi = u[1] ? 105 : 110;
    lo = u[0] ? 95 : 90;
    return (m * 100 > sp * hi) || (m * 100 < sp * lo);
  endfunction
  function automatic int edge_m(input logic [1:0] u, j);
    int h;
    h = j[1] ? (u[0] ? 950 : 900) : (u[1] ? 1050 : 1100);
    return h + (j[0] ? (j[1] ? -1 : 1) : 0);
  endfunction

  // ---
  // drivers
  // ---
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic reg_op(input logic [1:0] o, input logic [7:0] a, d, k);
    int t;
    @(negedge clk);
    op = o;
    addr = a;
    wdata = d;
    mask = k;
    go = 1'b1;
    for (t = 0; t < 40 && done !== 1'b1; t++)
      tick(1);
    `CHK("reg_done", 1'b1, done)
    go = 1'b0;
  endtask
  task automatic pg_start(input logic [7:0] d, input int lo, hi);
    int n;
    steady_state = 1'b0;
    ramping_down = 1'b1;
    vout_setpoint = 12'h3E8;
    vout_measured = 12'h000;
    tick(3);
    ramping_down = 1'b0;
    reg_op(2'h1, `OWM_ADDR_DLY, d, 8'hFF);
    `CHK("pg_idle", 1'b0, pg_warning)
    vout_measured = 12'h3E8;
    steady_state = 1'b1;
    for (n = 0; n < 900 && pg_oe !== 1'b0; n++)
      tick(1);
    `CHK("pg_release", 1'b1, n >= lo && n <= hi)
  endtask
  task automatic end_sim();
    $display("tests=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #2000000;
    err_count++;
    $display("MISMATCH watchdog exp=1 got=0");
    end_sim();
  end
  initial begin : main
    int k, m;
    logic [1:0] u;
    logic [11:0] sp;
    logic [7:0] v;
    void'($urandom(32'h7f4548bd));
    {reset, poll_en, go, op, addr, wdata, mask} = {1'b1, 28'h0};
    {steady_state, turn_off_cmd, ramping_down, ext_low} = 4'h0;
    temp_c = 8'h19;
    vout_setpoint = 12'h000;
    vout_measured = 12'h000;
    tick(3);
    reset = 1'b0;
    poll_en = 1'b1;
    for (k = 0; k < 5; k++) begin
      reg_op(2'h0, RA[k], 8'h00, 8'h00);
      `CHK("reg_reset", RV[k], rdata)
    end
    for (k = 0; k < 4; k++) begin
      v = 8'($urandom);
      reg_op(2'h2, `OWM_ADDR_CLS, v, 8'h0F);
      `CHK("limit_level", v[3:0], current_limit_level)
      `CHK("reg_slope", 3'h0, load_regulation_slope)
      `CHK("reg_tempco", 1'b1, limit_temp_comp_enable)
    end
    for (k = 0; k < 16; k++) begin
      sp = 12'($urandom);
      vout_setpoint = sp;
      reg_op(2'h1, `OWM_ADDR_PTC, {4'hC, 4'(k)}, 8'hFF);
      reg_op(2'h0, `OWM_ADDR_PTC, 8'h00, 8'h00);
      `CHK("ptc_read", {4'h0, 4'(k)}, rdata)
      `CHK("ov_thr", sp * ovp(2'(k >> 2)), ov_threshold)
      `CHK("uv_thr", sp * uvp(2'(k)), uv_threshold)
    end
    for (k = 0; k < 7; k++) begin
      temp_c = TT[k];
      tick(12);
      `CHK("temp_warn", TW[k], overtemp_warning)
      `CHK("st_temp", TW[k], status[`OWM_ST_TEMP])
      `CHK("no_stop", 1'b0, pg_warning)
    end
    v = 8'($urandom % 20);
    pg_start(v, v * CPM, v * CPM + 5);
    pg_start(8'hFF, 150 * CPM, 150 * CPM + 5);
    reg_op(2'h0, `OWM_ADDR_DLY, 8'h00, 8'h00);
    `CHK("dly_clamp", `OWM_DLY_MAX_MS, rdata)
    pg_start(8'h00, 0, 5);
    for (k = 0; k < 24; k++) begin
      u = 2'(k);
      reg_op(2'h1, `OWM_ADDR_PTC, {2'h0, u, 4'h8}, 8'hFF);
      m = (k < 16) ? edge_m(u, 2'(k >> 2)) : 850 + $urandom % 300;
      vout_measured = 12'(m);
      tick(4);
      `CHK("pg_drive", bad(u, 1000, m), pg_oe)
      `CHK("pg_warn", bad(u, 1000, m), pg_warning)
      tick(10);
      `CHK("st_ok", !bad(u, 1000, m), status[`OWM_ST_OK])
    end
    vout_setpoint = 12'h44C;
    vout_measured = 12'h44C;
    tick(4);
    `CHK("margin_ok", 1'b0, pg_warning)
    vout_measured = 12'h3E8;
    tick(4);
    `CHK("margin_bad", 1'b1, pg_warning)
    vout_setpoint = 12'h3E8;
    tick(4);
    ext_low = 1'b1;
    tick(5);
    `CHK("ext_warn", 1'b1, pg_warning)
    `CHK("ext_oe", 1'b0, pg_oe)
    tick(10);
    `CHK("ext_st", 1'b0, status[`OWM_ST_OK])
    ext_low = 1'b0;
    tick(5);
    `CHK("ext_gone", 1'b0, pg_warning)
    for (k = 0; k < 2; k++) begin
      reg_op(2'h1, `OWM_ADDR_OPT, 8'(k), 8'hFF);
      pg_start(8'h00, 0, 5);
      turn_off_cmd = 1'b1;
      tick(1);
      turn_off_cmd = 1'b0;
      tick(3);
      `CHK("off_cmd", 1'(k), pg_oe)
      ramping_down = 1'b1;
      tick(3);
      `CHK("off_ramp", 1'b1, pg_oe)
    end
    end_sim();
  end
endmodule // test_output_warning_threshold_monitor
`default_nettype wire
